// [dv/dds_host_model.sv]
// Purpose: Behavioural serial host driving both die selects, clock, data in and the reset pin
// Assumes: Mode 0 framing; sck half period of five clk cycles; si inverted whenever it carries nothing
// Notes:   Received bytes land in rx_q for the bench to inspect
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Serial host model
// ----------------------------------------------------------------------------
module dds_host_model
(
  input  wire logic clk,
  output logic      sck,
  output logic      si,
  output logic      die_a_select_n,
  output logic      die_b_select_n,
  output logic      hw_reset_n,
  input  wire logic so,
  input  wire logic so_oe
);
  localparam int HALF = 5;   // Above the four-cycle minimum half period
  localparam int GAP  = 13;  // 52 ns keeps the slower program/erase select gap too

  logic [7:0] rx_q[$];
  logic [7:0] bits;

  // Idle pins: clock parked low, selects and reset pin high
  initial
  begin
    sck            = 1'b0;
    si             = 1'b0;
    die_a_select_n = 1'b1;
    die_b_select_n = 1'b1;
    hw_reset_n     = 1'b1;
    bits           = 8'h00;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One frame; sel bit 0 picks die a, bit 1 die b, both only when a scenario wants a refusal
  task automatic xfer(input logic [1:0] sel, input logic [39:0] tx, input int ntx, input int nrx);
    int i;
    rx_q.delete();
    die_a_select_n = ~sel[0];
    die_b_select_n = ~sel[1];
    wait_clk(HALF);
    for (i = 0; i < 8 * (ntx + nrx); i++)
    begin
      sck = 1'b0;
      si  = (i < 8 * ntx) ? tx[8 * ntx - 1 - i] : ~si;
      wait_clk(HALF);
      if (i >= 8 * ntx)
      begin
        bits = {bits[6:0], so};
        if (i % 8 == 7)
          rx_q.push_back(bits);
      end
      sck = 1'b1;
      wait_clk(HALF);
    end
    sck = 1'b0;
    si  = ~si;  // Released line shows no stale value
    wait_clk(HALF);
    die_a_select_n = 1'b1;
    die_b_select_n = 1'b1;
    wait_clk(GAP);
  endtask

  // Pulse the reset pin low, then let the synchronisers settle
  task automatic hw_pulse();
    hw_reset_n = 1'b0;
    wait_clk(8);
    hw_reset_n = 1'b1;
    wait_clk(8);
  endtask
endmodule

// [dv/dual_die_spi_flash_select_bench.sv]
// Purpose: Self-checking bench for the two-die serial flash device side
// Assumes: Array modelled as a pure function of die and address
// Notes:   Erase pulses are counted per die and compared after the erase and reset pin scenarios
`timescale 1ns/10ps

module dual_die_spi_flash_select_bench;
  import dds_pkg::*;
  localparam logic [7:0] ID_M = 8'h3c;  // Arbitrary value
  localparam logic [7:0] ID_H = 8'h61;  // Arbitrary value
  localparam logic [7:0] ID_L = 8'h7e;  // Arbitrary value
  localparam logic [1:0] DA   = 2'b01;
  localparam logic [1:0] DB   = 2'b10;

  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  wire               sck, si, sel_a_n, sel_b_n, hw_n, so, so_oe, mem_die;
  wire  [DIE_AW-1:0] mem_addr, erase_addr;
  wire  [7:0]        mem_rdata;
  wire  [1:0]        erase_sector, erase_bulk;
  logic [7:0]        bulk_a = 8'h00, bulk_b = 8'h00, sect_a = 8'h00, sect_b = 8'h00;
  logic [DIE_AW-1:0] sect_addr = '0;
  int                error_cnt = 0;
  int                n_tests = 0;

  function automatic logic [7:0] mem_byte(input logic d, input logic [DIE_AW-1:0] a);
    return a[7:0] ^ {d, 7'h2a};
  endfunction

  function automatic logic [7:0] id_byte(input int i);
    return (i == 0) ? ID_M : (i == 1) ? ID_H : (i == 2) ? ID_L : (i == 'h27) ? 8'h1b : 8'hff;
  endfunction

  assign mem_rdata = mem_byte(mem_die, mem_addr);

  always #2 clk = ~clk;

  // Erase pulse counters; erase address taken with the die b sector pulse
  always @(posedge clk)
  begin
    if (erase_bulk[0]) bulk_a <= bulk_a + 8'h01;
    if (erase_bulk[1]) bulk_b <= bulk_b + 8'h01;
    if (erase_sector[0]) sect_a <= sect_a + 8'h01;
    if (erase_sector[1]) sect_b <= sect_b + 8'h01;
    if (erase_sector[1]) sect_addr <= erase_addr;
  end

  dds_top #(.MANUF_ID(ID_M), .DEV_ID_HI(ID_H), .DEV_ID_LO(ID_L), .CFI_FILL(8'hff)) dds_top_i
  (
    .clk            (clk),
    .nrst           (nrst),
    .sck            (sck),
    .si             (si),
    .die_a_select_n (sel_a_n),
    .die_b_select_n (sel_b_n),
    .hw_reset_n     (hw_n),
    .so             (so),
    .so_oe          (so_oe),
    .mem_addr       (mem_addr),
    .mem_die        (mem_die),
    .mem_rdata      (mem_rdata),
    .erase_sector   (erase_sector),
    .erase_bulk     (erase_bulk),
    .erase_addr     (erase_addr)
  );

  dds_host_model dds_host_model_i
  (
    .clk            (clk),
    .sck            (sck),
    .si             (si),
    .die_a_select_n (sel_a_n),
    .die_b_select_n (sel_b_n),
    .hw_reset_n     (hw_n),
    .so             (so),
    .so_oe          (so_oe)
  );

  // ----------------------------------------------------------------------------
  // Compare and access tasks
  // ----------------------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_addr(input logic [DIE_AW-1:0] got, input logic [DIE_AW-1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t address got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [1:0] s, input logic [7:0] c);
    dds_host_model_i.xfer(s, {32'h0, c}, 1, 0);
  endtask

  // Read one register byte and compare the bits under mask
  task automatic rd_chk(input logic [1:0] s, input logic [7:0] c, input logic [7:0] e, input logic [7:0] m);
    dds_host_model_i.xfer(s, {32'h0, c}, 1, 1);
    chk8(dds_host_model_i.rx_q[0] & m, e);
  endtask

  task automatic wr_regs(input logic [1:0] s, input logic [7:0] sr_v, input logic [7:0] cr_v);
    cmd(s, CMD_WREN);
    dds_host_model_i.xfer(s, {16'h0, CMD_WRR, sr_v, cr_v}, 3, 0);
  endtask

  // Reset held 16 cycles, then settling time before the first select
  task automatic do_reset();
    nrst = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    nrst = 1'b1;
    dds_host_model_i.wait_clk(8);
  endtask

  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  initial
  begin
    int d;
    int i;
    int k;
    do_reset();
    rd_chk(DA, CMD_RDSR, 8'h00, 8'hff);
    rd_chk(DA, CMD_RDCR, 8'h00, 8'hff);
    rd_chk(DB, CMD_RDSR, 8'h00, 8'hff);
    rd_chk(DB, CMD_RDCR, 8'h00, 8'hff);
    // Identification stream from each die, past the size byte
    for (d = 0; d < 2; d++)
    begin
      dds_host_model_i.xfer(d ? DB : DA, {32'h0, CMD_IDENT}, 1, 42);
      for (i = 0; i < 42; i++)
        chk8(dds_host_model_i.rx_q[i], id_byte(i));
    end
    // Die a gets a protected range and new config; die b must stay untouched
    wr_regs(DA, 8'h1c, 8'h28);
    rd_chk(DA, CMD_RDSR, 8'h1c, 8'h9c);
    rd_chk(DA, CMD_RDCR, 8'h28, 8'hff);
    rd_chk(DB, CMD_RDSR, 8'h00, 8'hff);
    rd_chk(DB, CMD_RDCR, 8'h00, 8'hff);
    // Both bulk erase codes: refused on protected die a, taken on die b
    for (k = 0; k < 2; k++)
    begin
      cmd(DA, CMD_WREN);
      cmd(DA, k ? CMD_BE_B : CMD_BE_A);
      cmd(DB, CMD_WREN);
      cmd(DB, k ? CMD_BE_B : CMD_BE_A);
    end
    cmd(DB, CMD_BE_B);
    cmd(2'b11, CMD_WREN);
    cmd(DB, CMD_BE_B);
    chk8(bulk_a, 8'h00);
    chk8(bulk_b, 8'h02);
    // Sector erase: upper address bits dropped, die taken from the select
    cmd(DA, CMD_WREN);
    dds_host_model_i.xfer(DA, {CMD_SE, 32'hfd23_4560}, 5, 0);
    cmd(DB, CMD_WREN);
    dds_host_model_i.xfer(DB, {CMD_SE, 32'hfd23_4560}, 5, 0);
    chk8(sect_a, 8'h00);
    chk8(sect_b, 8'h01);
    chk_addr(sect_addr, 26'h123_4560);
    // Read across the die end wraps within die b
    dds_host_model_i.xfer(DB, {CMD_READ, 32'h03ff_ffff}, 5, 2);
    chk8(dds_host_model_i.rx_q[0], mem_byte(1'b1, 26'h3ff_ffff));
    chk8(dds_host_model_i.rx_q[1], mem_byte(1'b1, 26'h000_0000));
    dds_host_model_i.xfer(DA, {CMD_READ, 32'h0000_0005}, 5, 1);
    chk8(dds_host_model_i.rx_q[0], mem_byte(1'b0, 26'h000_0005));
    // Reset pin drops the write enable and the output
    cmd(DB, CMD_WREN);
    dds_host_model_i.hw_pulse();
    cmd(DB, CMD_BE_A);
    chk8(bulk_b, 8'h02);
    chk8({7'h0, so_oe}, 8'h00);
    // Lock bit holds through writes and the reset pin, clears on power-on reset
    wr_regs(DB, 8'h00, 8'h01);
    wr_regs(DB, 8'h1c, 8'h00);
    rd_chk(DB, CMD_RDCR, 8'h01, 8'hff);
    rd_chk(DB, CMD_RDSR, 8'h00, 8'h9c);
    dds_host_model_i.hw_pulse();
    rd_chk(DB, CMD_RDCR, 8'h01, 8'hff);
    rd_chk(DA, CMD_RDCR, 8'h28, 8'hff);
    do_reset();
    rd_chk(DB, CMD_RDCR, 8'h00, 8'hff);
    // Matching settings on both dies keep behaviour the same across a die switch
    wr_regs(DA, 8'h00, 8'h20);
    wr_regs(DB, 8'h00, 8'h20);
    rd_chk(DA, CMD_RDCR, 8'h20, 8'hff);
    rd_chk(DB, CMD_RDCR, 8'h20, 8'hff);
    summarize();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule

// [rtl/dds_die_regs.sv]
// Purpose: Package of shared constants and the per-die register state of the stacked-die serial flash
// Assumes: One instance per die; the shared serial engine in dds_top drives the write strobes
// Notes:   The freeze bit is cleared only by the power-on reset (rst_n), never by the reset pin

// ----------------------------------------------------------------------------
// Shared constants
// ----------------------------------------------------------------------------
package dds_pkg;
  localparam int          NUM_DIES     = 2;
  localparam int          DIE_AW       = 26;      // Byte address width inside one die
  localparam logic [4:0]  PIN_IDLE     = 5'h1c;   // {reset, sel_b, sel_a, si, sck} at rest
  localparam logic [7:0]  CMD_WRR      = 8'h01;
  localparam logic [7:0]  CMD_WRDI     = 8'h04;
  localparam logic [7:0]  CMD_RDSR     = 8'h05;
  localparam logic [7:0]  CMD_WREN     = 8'h06;
  localparam logic [7:0]  CMD_READ     = 8'h13;   // Four-byte address read
  localparam logic [7:0]  CMD_RDCR     = 8'h35;
  localparam logic [7:0]  CMD_BE_A     = 8'h60;
  localparam logic [7:0]  CMD_IDENT    = 8'h9f;   // read_ident_cmd
  localparam logic [7:0]  CMD_BE_B     = 8'hc7;
  localparam logic [7:0]  CMD_SE       = 8'hdc;   // Four-byte address sector erase
  localparam int          SR_WEL       = 1;
  localparam int          SR_BP_LO     = 2;
  localparam int          SR_BP_HI     = 4;
  localparam logic [7:0]  SR_WR_MASK   = 8'h9c;   // Writable status bits: SRWD and BP
  localparam int          CR_FREEZE    = 0;
  localparam int          CR_PERSIST   = 3;       // protect_bits_persistence_select
  localparam int          CR_BASE_SEL  = 5;       // protect_base_select, 0 = top of array
  localparam logic [7:0]  CR_WR_MASK   = 8'h3f;
  localparam logic [7:0]  SR_RESET     = 8'h00;   // Empty protected range
  localparam logic [7:0]  CR_RESET     = 8'h00;   // Range based at top, unfrozen
  localparam logic [7:0]  CFI_SIZE_OFS = 8'h27;
  localparam logic [7:0]  CFI_SIZE_VAL = 8'h1b;   // 2^27 bytes for the package
  localparam logic [2:0]  ADDR_BYTES   = 3'h4;
endpackage

`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Per-die status and configuration registers
// ----------------------------------------------------------------------------
module dds_die_regs
  import dds_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       hw_rst,
  input  wire logic       wel_set,
  input  wire logic       wel_clr,
  input  wire logic       wrr_go,
  input  wire logic       wrr_cr_valid,
  input  wire logic [7:0] wrr_sr,
  input  wire logic [7:0] wrr_cr,
  output logic      [7:0] sr,
  output logic      [7:0] cr
);
  logic [7:0] sr_r;
  logic [7:0] sr_nxt;
  logic [7:0] cr_r;
  logic [7:0] cr_nxt;
  logic       frozen;
  logic [7:0] sr_mask;

  // Freeze also locks the protection bits of the status register
  assign frozen  = cr_r[CR_FREEZE];
  assign sr_mask = frozen ? 8'h00 : SR_WR_MASK;

  // Status: write enable latch plus masked write; the reset pin drops the latch
  always_comb
  begin
    sr_nxt = sr_r;
    if (wrr_go)
      sr_nxt = (sr_r & ~sr_mask) | (wrr_sr & sr_mask);
    if (wel_set)
      sr_nxt[SR_WEL] = 1'b1;
    if (wel_clr || hw_rst)
      sr_nxt[SR_WEL] = 1'b0;
  end

  // Config: freeze is sticky, so a write can only add it
  always_comb
  begin
    cr_nxt = cr_r;
    if (wrr_go && wrr_cr_valid && !frozen)
      cr_nxt = (cr_r & ~CR_WR_MASK) | (wrr_cr & CR_WR_MASK);
    cr_nxt[CR_FREEZE] = cr_r[CR_FREEZE] | (wrr_go && wrr_cr_valid && wrr_cr[CR_FREEZE]);
  end

  // Only the power-on reset restores defaults
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sr_r <= SR_RESET;
      cr_r <= CR_RESET;
    end
    else
    begin
      sr_r <= sr_nxt;
      cr_r <= cr_nxt;
    end
  end

  assign sr = sr_r;
  assign cr = cr_r;

  freeze_sticky_a : assert property (@(posedge clk) disable iff (!rst_n)
    cr_r[CR_FREEZE] |=> cr_r[CR_FREEZE])
    else $error("freeze bit cleared without power-on reset");

  frozen_bp_hold_a : assert property (@(posedge clk) disable iff (!rst_n)
    frozen |=> $stable(sr_r[SR_BP_HI:SR_BP_LO]) && $stable(cr_r[CR_BASE_SEL]) && $stable(cr_r[CR_PERSIST]))
    else $error("protection changed while frozen");

  hwrst_wel_a : assert property (@(posedge clk) disable iff (!rst_n)
    hw_rst |=> !sr_r[SR_WEL])
    else $error("write enable survived reset pin");
endmodule

// [rtl/dds_top.sv]
// Purpose: Device side of a two-die serial flash stack sharing one serial bus, one select per die
// Assumes: Serial mode 0; SCK half period of at least four clk cycles; array lives outside
// Notes:   mem_rdata must be valid for mem_addr within two clk cycles of a mem_addr change
//
// Operation
// - Continuous read wraps inside its die, never rolls into the other die.
// - Bulk erase acts on the selected die only; one command per die.
// - Each die has its own status register, read and written separately.
// - Each die has its own configuration register, written separately.
// - Protect base and persistence select bits are written per die.
// - Default protection range sits at the top and covers nothing.
// - Per-die lock bit, once set, clears only on power-on reset.
// - Identification read gives maker byte, two device bytes, then table bytes.
// - Identification byte 27h reads 1Bh, the package size exponent.
// - Reset pin low returns the device to standby.
`timescale 1ns/10ps

module dds_top
  import dds_pkg::*;
#(
  parameter logic [7:0] MANUF_ID   = 8'h5a,  // Arbitrary value
  parameter logic [7:0] DEV_ID_HI  = 8'h12,  // Arbitrary value
  parameter logic [7:0] DEV_ID_LO  = 8'h34,  // Arbitrary value
  parameter logic [7:0] CFI_FILL   = 8'hff
)
(
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       sck,
  input  wire logic                       si,
  input  wire logic                       die_a_select_n,
  input  wire logic                       die_b_select_n,
  input  wire logic                       hw_reset_n,
  output logic                            so,
  output logic                            so_oe,
  output logic [dds_pkg::DIE_AW-1:0]      mem_addr,
  output logic                            mem_die,
  input  wire logic [7:0]                 mem_rdata,
  output logic [dds_pkg::NUM_DIES-1:0]    erase_sector,
  output logic [dds_pkg::NUM_DIES-1:0]    erase_bulk,
  output logic [dds_pkg::DIE_AW-1:0]      erase_addr
);
  import dds_pkg::*;

  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_WIN, PH_OUT, PH_IGN} dds_phase_e;

  logic                 rst_s1_r;
  logic                 rst_n;
  logic [4:0]           pin_s1_r;
  logic [4:0]           pin_s2_r;
  logic                 sck_d_r;
  logic                 active_d_r;
  dds_phase_e           phase_r;
  logic [7:0]           cmd_r;
  logic [2:0]           bit_cnt_r;
  logic [6:0]           in_sh_r;
  logic [31:0]          addr_r;
  logic [2:0]           addr_cnt_r;
  logic [1:0]           win_cnt_r;
  logic [7:0]           sr_buf_r;
  logic [7:0]           cr_buf_r;
  logic [7:0]           out_sh_r;
  logic [7:0]           idx_r;
  logic [DIE_AW-1:0]    mem_addr_r;
  logic                 die_r;
  logic                 so_oe_r;
  logic [NUM_DIES-1:0]  erase_sector_r;
  logic [NUM_DIES-1:0]  erase_bulk_r;
  logic [DIE_AW-1:0]    erase_addr_r;
  logic [7:0]           sr_v [NUM_DIES];
  logic [7:0]           cr_v [NUM_DIES];

  // ----------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // Pins are asynchronous to clk, so two flops before any use
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= PIN_IDLE;
      pin_s2_r <= PIN_IDLE;
    end
    else
    begin
      pin_s1_r <= {hw_reset_n, die_b_select_n, die_a_select_n, si, sck};
      pin_s2_r <= pin_s1_r;
    end
  end

  // ----------------------------------------------------------------------------
  // Select, edge and byte decode
  // ----------------------------------------------------------------------------
  logic       sck_s, si_s, sel_a, sel_b, hw_rst, active, sck_rise, sck_fall;
  logic       byte_done, load, clean, commit;
  logic [7:0] byte_in;
  assign sck_s     = pin_s2_r[0];
  assign si_s      = pin_s2_r[1];
  assign sel_a     = !pin_s2_r[2];
  assign sel_b     = !pin_s2_r[3];
  assign hw_rst    = !pin_s2_r[4];
  assign active    = (sel_a ^ sel_b) && !hw_rst;  // both low is treated as no selection
  assign sck_rise  = sck_s && !sck_d_r;
  assign sck_fall  = !sck_s && sck_d_r;
  assign byte_in   = {in_sh_r, si_s};
  assign byte_done = active && sck_rise && (bit_cnt_r == 3'h7);
  assign load      = active && sck_fall && (phase_r == PH_OUT) && (bit_cnt_r == 3'h0);
  assign clean     = (bit_cnt_r == 3'h0);
  // Commands act when their own die's select rises on a byte boundary
  assign commit    = active_d_r && !active && !hw_rst && clean && pin_s2_r[2 + die_r];

  // Phase that follows the command byte
  dds_phase_e cmd_phase;
  assign cmd_phase = (byte_in == CMD_RDSR || byte_in == CMD_RDCR || byte_in == CMD_IDENT) ? PH_OUT :
                     (byte_in == CMD_READ || byte_in == CMD_SE) ? PH_ADDR :
                     (byte_in == CMD_WRR) ? PH_WIN : PH_IGN;

  // ----------------------------------------------------------------------------
  // Per-die commit decode
  // ----------------------------------------------------------------------------
  logic [7:0] sr_cur, cr_cur;
  logic       wel_cur, unprot, go_wren, go_wrdi, go_wrr, go_se, go_be;
  assign sr_cur  = sr_v[die_r];
  assign cr_cur  = cr_v[die_r];
  assign wel_cur = sr_cur[SR_WEL];
  // Any nonzero protect field refuses erases; with the defaults nothing is protected
  assign unprot  = (sr_cur[SR_BP_HI:SR_BP_LO] == 3'h0);
  assign go_wren = commit && (phase_r == PH_IGN) && (cmd_r == CMD_WREN);
  assign go_wrdi = commit && (phase_r == PH_IGN) && (cmd_r == CMD_WRDI);
  assign go_wrr  = commit && (phase_r == PH_WIN) && (win_cnt_r != 2'h0) && wel_cur;
  assign go_se   = commit && (phase_r == PH_IGN) && (cmd_r == CMD_SE) && (addr_cnt_r == ADDR_BYTES)
                   && wel_cur && unprot;
  assign go_be   = commit && (phase_r == PH_IGN) && (cmd_r == CMD_BE_A || cmd_r == CMD_BE_B)
                   && wel_cur && unprot;

  // One register set per die, written only under that die's own select
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIES; gi++)
    begin : g_die
      logic mine;
      assign mine = (die_r == 1'(gi));
      dds_die_regs u_regs (
        .clk          (clk),
        .rst_n        (rst_n),
        .hw_rst       (hw_rst),
        .wel_set      (go_wren && mine),
        .wel_clr      ((go_wrdi || go_wrr || go_se || go_be) && mine),
        .wrr_go       (go_wrr && mine),
        .wrr_cr_valid (win_cnt_r[1]),
        .wrr_sr       (sr_buf_r),
        .wrr_cr       (cr_buf_r),
        .sr           (sr_v[gi]),
        .cr           (cr_v[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Outgoing byte selection
  // ----------------------------------------------------------------------------
  logic [7:0] id_byte, out_byte;
  assign id_byte  = (idx_r == 8'h00) ? MANUF_ID :
                    (idx_r == 8'h01) ? DEV_ID_HI :
                    (idx_r == 8'h02) ? DEV_ID_LO :
                    (idx_r == CFI_SIZE_OFS) ? CFI_SIZE_VAL : CFI_FILL;
  assign out_byte = (cmd_r == CMD_RDSR) ? sr_cur :
                    (cmd_r == CMD_RDCR) ? cr_cur :
                    (cmd_r == CMD_IDENT) ? id_byte : mem_rdata;

  // ----------------------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------------------
  // Deselect or reset pin puts the engine back in standby
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_d_r    <= 1'b0;
      active_d_r <= 1'b0;
      phase_r    <= PH_CMD;
      cmd_r      <= 8'h00;
      bit_cnt_r  <= 3'h0;
      in_sh_r    <= 7'h00;
      addr_r     <= 32'h0;
      addr_cnt_r <= 3'h0;
      win_cnt_r  <= 2'h0;
      sr_buf_r   <= 8'h00;
      cr_buf_r   <= 8'h00;
      out_sh_r   <= 8'h00;
      idx_r      <= 8'h00;
      mem_addr_r <= '0;
      die_r      <= 1'b0;
      so_oe_r    <= 1'b0;
    end
    else
    begin
      sck_d_r    <= sck_s;
      active_d_r <= active;
      if (!active)
      begin
        phase_r    <= PH_CMD;
        bit_cnt_r  <= 3'h0;
        idx_r      <= 8'h00;
        addr_cnt_r <= 3'h0;
        win_cnt_r  <= 2'h0;
        so_oe_r    <= 1'b0;
      end
      else
      begin
        die_r <= sel_b;
        if (sck_rise)
        begin
          bit_cnt_r <= bit_cnt_r + 3'h1;
          in_sh_r   <= byte_in[6:0];
        end
        if (byte_done)
        begin
          unique case (phase_r)
            PH_CMD:
            begin
              cmd_r   <= byte_in;
              phase_r <= cmd_phase;
            end
            PH_ADDR:
            begin
              addr_r     <= {addr_r[23:0], byte_in};
              addr_cnt_r <= addr_cnt_r + 3'h1;
              if (addr_cnt_r == ADDR_BYTES - 3'h1)
              begin
                phase_r    <= (cmd_r == CMD_READ) ? PH_OUT : PH_IGN;
                mem_addr_r <= {addr_r[DIE_AW-9:0], byte_in};  // Upper bits pick no die here
              end
            end
            PH_WIN:
            begin
              if (win_cnt_r == 2'h0)
                sr_buf_r <= byte_in;
              if (win_cnt_r == 2'h1)
                cr_buf_r <= byte_in;
              if (win_cnt_r != 2'h2)
                win_cnt_r <= win_cnt_r + 2'h1;
            end
            PH_OUT, PH_IGN:
            begin
            end
          endcase
        end
        if (load)
        begin
          out_sh_r <= out_byte;
          so_oe_r  <= 1'b1;
          if (idx_r != 8'hff)
            idx_r <= idx_r + 8'h01;
          if (cmd_r == CMD_READ)
            mem_addr_r <= mem_addr_r + 1'b1;  // wraps within the die
        end
        else if (active && sck_fall)
          out_sh_r <= {out_sh_r[6:0], 1'b0};
      end
    end
  end

  // Erase strobes go only to the die that was selected
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      erase_sector_r <= '0;
      erase_bulk_r   <= '0;
      erase_addr_r   <= '0;
    end
    else
    begin
      erase_sector_r <= go_se ? NUM_DIES'(1 << die_r) : '0;
      erase_bulk_r   <= go_be ? NUM_DIES'(1 << die_r) : '0;
      if (go_se)
        erase_addr_r <= addr_r[DIE_AW-1:0];
    end
  end

  assign so           = out_sh_r[7];
  assign so_oe        = so_oe_r;
  assign mem_addr     = mem_addr_r;
  assign mem_die      = die_r;
  assign erase_sector = erase_sector_r;
  assign erase_bulk   = erase_bulk_r;
  assign erase_addr   = erase_addr_r;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  both_sel_quiet_a : assert property (@(posedge clk) disable iff (!rst_n)
    (sel_a && sel_b) ##1 (sel_a && sel_b) |-> !so_oe_r)
    else $error("output driven with both dies selected");

  read_wrap_a : assert property (@(posedge clk) disable iff (!rst_n)
    load && cmd_r == CMD_READ && (&mem_addr_r) |=> mem_addr_r == '0)
    else $error("read crossed the die boundary");

  erase_onehot_a : assert property (@(posedge clk) disable iff (!rst_n)
    $onehot0({erase_sector_r, erase_bulk_r}))
    else $error("erase strobed on more than one die");

  erase_wel_a : assert property (@(posedge clk) disable iff (!rst_n)
    (erase_sector_r != '0 || erase_bulk_r != '0) |-> $past(wel_cur) && $past(commit))
    else $error("erase without write enable");

  ident_size_a : assert property (@(posedge clk) disable iff (!rst_n)
    load && cmd_r == CMD_IDENT && idx_r == CFI_SIZE_OFS |=> out_sh_r == CFI_SIZE_VAL)
    else $error("size byte wrong");

  ident_first_a : assert property (@(posedge clk) disable iff (!rst_n)
    load && cmd_r == CMD_IDENT && idx_r == 8'h00 |=> out_sh_r == MANUF_ID ##0 idx_r == 8'h01)
    else $error("identification order wrong");

  standby_a : assert property (@(posedge clk) disable iff (!rst_n)
    hw_rst |=> phase_r == PH_CMD && !so_oe_r)
    else $error("reset pin did not return to standby");

  status_sep_a : assert property (@(posedge clk) disable iff (!rst_n)
    go_wrr && die_r |=> $stable(sr_v[0][SR_BP_HI:SR_BP_LO]))
    else $error("status write leaked to other die");
endmodule
